// ---- verilog/reset_clock_control_unit.sv ----
`timescale 1ns/100ps
`include "rcc_params.svh"
module reset_clock_control_unit
	import rcc_pkg::*;
(
	input  wire logic        core_clk,          // system clock, 200 MHz
	input  wire logic        rst_b,             // sync reset, active low
	input  wire logic        hsel,              // slave select
	input  wire logic [11:0] haddr,             // byte address in window
	input  wire logic [1:0]  htrans,            // transfer type
	input  wire logic        hwrite,            // write transfer
	input  wire logic [2:0]  hsize,             // transfer size
	input  wire logic        hready,            // bus ready in
	input  wire logic [31:0] hwdata,            // write data
	output logic      [31:0] hrdata,            // read data
	output logic             hreadyout,         // slave ready
	output logic             hresp,             // error response
	input  wire logic        fast_internal_osc, // sampled osc level
	input  wire logic        multispeed_internal_osc, // sampled osc level
	input  wire logic        external_osc,      // sampled osc level
	input  wire logic        pll_clk,           // sampled PLL level
	input  wire logic        slow_internal_osc, // sampled osc level
	input  wire logic        slow_external_osc, // sampled osc level
	input  wire logic        usb_internal_osc,  // sampled osc level
	input  wire logic        low_power_mode,    // low-power mode active
	input  wire logic        low_power_wake,    // wake from stop/standby
	output logic      [4:0]  pll_prediv,        // PLL pre-divider
	output logic      [1:0]  pll_postdiv,       // PLL output divider
	output logic      [6:0]  pll_mul,           // PLL feedback multiplier
	output logic             pll_ref_sel,       // 1 external reference
	output logic      [1:0]  usb_clk_sel,       // USB clock source
	output logic      [1:0]  system_clock_sel,  // system clock source
	output logic             hclk_tick,         // AHB clock enable tick
	output logic             first_bus_tick,    // first bus clock tick
	output logic             second_bus_tick,   // second bus clock tick
	output logic             mco_pin,           // clock output pin
	output logic      [31:0] first_bus_module_rst,  // module resets
	output logic      [31:0] second_bus_module_rst, // module resets
	output logic      [31:0] ahb_module_rst,    // module resets
	output logic             rtc_rst,           // RTC reset
	output logic      [31:0] first_bus_run_gate, // effective gates
	output logic      [31:0] second_bus_clock_gate, // module gates
	output logic      [31:0] ahb_clock_gate     // module gates
);
	localparam logic [9:0][31:0] WR_MASK = {
		`MASK_LPGATE0, `MASK_GATEH, `MASK_GATE1, `MASK_GATE0, `MASK_RSTH,
		`MASK_RST1, `MASK_RST0, `MASK_DIV, `MASK_SRC, `MASK_PLL};
	localparam logic [9:0][31:0] RST_VAL = {
		`RST_LPGATE0, `RST_GATEH, `RST_GATE1, `RST_GATE0, `RST_RST,
		`RST_RST, `RST_RST, `RST_DIV, `RST_SRC, `RST_PLL};

	state_type   cur;
	state_type   next_cur;
	logic        addr_ok;
	logic [3:0]  addr_idx;
	logic        take;
	logic [3:0]  ahb_sel;
	logic [3:0]  first_sel;
	logic [3:0]  second_sel;
	logic [3:0]  mco_div_sel;
	logic        ahb_tick_c;
	logic        first_tick_c;
	logic        second_tick_c;
	logic        mco_tick_c;
	logic        mco_src_lvl;
	logic [2:0]  mco_pres;
	logic [31:0] div_word;
	logic [31:0] src_word;

	// byte offset to register index
	always_comb
	begin
		addr_ok  = 1'b1;
		addr_idx = 4'h0;
		unique case (haddr)
			`OFF_PLL_CLOCK_SETTINGS:      addr_idx = `IDX_PLL;
			`OFF_CLOCK_SOURCE_CONTROL:    addr_idx = `IDX_SRC;
			`OFF_CLOCK_DIVIDER_CONFIG:    addr_idx = `IDX_DIV;
			`OFF_FIRST_BUS_MODULE_RESET:  addr_idx = `IDX_RST0;
			`OFF_SECOND_BUS_MODULE_RESET: addr_idx = `IDX_RST1;
			`OFF_AHB_MODULE_RESET:        addr_idx = `IDX_RSTH;
			`OFF_FIRST_BUS_CLOCK_GATE:    addr_idx = `IDX_GATE0;
			`OFF_SECOND_BUS_CLOCK_GATE:   addr_idx = `IDX_GATE1;
			`OFF_AHB_CLOCK_GATE:          addr_idx = `IDX_GATEH;
			`OFF_FIRST_BUS_LOWPOWER_GATE: addr_idx = `IDX_LPGATE0;
			default:                      addr_ok  = 1'b0;
		endcase
	end

	assign take     = hsel & hready & htrans[1];
	assign div_word = cur.regs[`IDX_DIV];
	assign src_word = cur.regs[`IDX_SRC];

	// out-of-range prescaler codes saturate at the largest division
	always_comb
	begin
		ahb_sel = div_word[`AHB_PRES_HI:`AHB_PRES_LO];
		if (ahb_sel > `AHB_PRES_MAX)
			ahb_sel = `AHB_PRES_MAX;
		first_sel = {1'b0, div_word[`FIRST_PRES_HI:`FIRST_PRES_LO]};
		if (first_sel > {1'b0, `BUS_PRES_MAX})
			first_sel = {1'b0, `BUS_PRES_MAX};
		second_sel = {1'b0, div_word[`SECOND_PRES_HI:`SECOND_PRES_LO]};
		if (second_sel > {1'b0, `BUS_PRES_MAX})
			second_sel = {1'b0, `BUS_PRES_MAX};
		mco_pres = div_word[`MCO_PRES_HI:`MCO_PRES_LO];
		if (mco_pres > `MCO_PRES_MAX)
			mco_pres = `MCO_PRES_MAX;
		// the toggling output already halves, so count one step less
		mco_div_sel = (mco_pres == 3'h0) ? 4'h0 : {1'b0, mco_pres - 3'h1};
	end

	// clock output source mux on the active selection
	always_comb
	begin
		mco_src_lvl = 1'b0;
		unique case (cur.mco_act)
			MCO_OFF:           mco_src_lvl = 1'b0;
			MCO_SYSTEM:        mco_src_lvl = ~cur.mco_src_q;
			MCO_FAST_INTERNAL: mco_src_lvl = fast_internal_osc;
			MCO_MULTISPEED:    mco_src_lvl = multispeed_internal_osc;
			MCO_EXTERNAL:      mco_src_lvl = external_osc;
			MCO_PLL:           mco_src_lvl = pll_clk;
			MCO_SLOW_INTERNAL: mco_src_lvl = slow_internal_osc;
			MCO_SLOW_EXTERNAL: mco_src_lvl = slow_external_osc;
			MCO_USB_INTERNAL:  mco_src_lvl = usb_internal_osc;
			default:           mco_src_lvl = 1'b0;
		endcase
	end

	clock_pow2_divider ahb_div (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.tick_in  (1'b1),
		.div_sel  (ahb_sel),
		.tick_out (ahb_tick_c)
	);

	clock_pow2_divider first_div (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.tick_in  (ahb_tick_c),
		.div_sel  (first_sel),
		.tick_out (first_tick_c)
	);

	clock_pow2_divider second_div (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.tick_in  (ahb_tick_c),
		.div_sel  (second_sel),
		.tick_out (second_tick_c)
	);

	clock_pow2_divider mco_div (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.tick_in  (mco_src_lvl & ~cur.mco_src_q),
		.div_sel  (mco_div_sel),
		.tick_out (mco_tick_c)
	);

	always_comb
	begin
		next_cur = cur;

		// bus: address phase then data phase write
		next_cur.wr_pend = take & hwrite & addr_ok;
		next_cur.wr_idx  = addr_idx;
		if (take & ~hwrite)
			next_cur.hrdata = addr_ok ? cur.regs[addr_idx] : 32'h0000_0000;
		if (cur.wr_pend)
			next_cur.regs[cur.wr_idx] =
				hwdata & WR_MASK[cur.wr_idx];

		// wake returns the system clock to multispeed
		if (low_power_wake)
			next_cur.regs[`IDX_SRC][`SYS_SEL_HI:`SYS_SEL_LO] = SYS_MULTISPEED;

		// bus ticks; first and second each held back by its gate bit, hclk_tick not gated
		next_cur.hclk_tick       = ahb_tick_c;
		next_cur.first_bus_tick  = first_tick_c &
			src_word[`FIRST_BUS_BIT];
		next_cur.second_bus_tick = second_tick_c &
			src_word[`SECOND_BUS_BIT];

		// clock output: selector changes only while the pin is low
		next_cur.mco_src_q = (cur.mco_act == MCO_SYSTEM) ?
			~cur.mco_src_q : mco_src_lvl;
		if (!cur.mco_pin)
			next_cur.mco_act = div_word[`MCO_SEL_HI:`MCO_SEL_LO];
		if (cur.mco_act == MCO_OFF)
			next_cur.mco_pin = 1'b0;
		else if (mco_pres == 3'h0)
			next_cur.mco_pin = mco_src_lvl;
		else if (mco_tick_c)
			next_cur.mco_pin = ~cur.mco_pin;

		// module resets follow their bits while set
		next_cur.first_bus_module_rst  = cur.regs[`IDX_RST0];
		next_cur.first_bus_module_rst[`RTC_RESET_BIT] = 1'b0;
		next_cur.second_bus_module_rst = cur.regs[`IDX_RST1];
		next_cur.ahb_module_rst        = cur.regs[`IDX_RSTH];
		next_cur.rtc_rst = cur.regs[`IDX_RST0][`RTC_RESET_BIT];

		// low-power mode keeps only first-bus modules with a low-power enable
		next_cur.first_bus_run_gate = cur.regs[`IDX_GATE0] &
			(low_power_mode ? cur.regs[`IDX_LPGATE0] : 32'hFFFF_FFFF);
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			cur                       <= '0;
			cur.regs                  <= RST_VAL;
			cur.first_bus_module_rst  <= 32'hFFFF_FFFF;
			cur.second_bus_module_rst <= 32'hFFFF_FFFF;
			cur.ahb_module_rst        <= 32'hFFFF_FFFF;
			cur.first_bus_run_gate    <= `RST_GATE0;
		end
		else
			cur <= next_cur;
	end

	// the RTC reset flop ignores the global reset
	logic rtc_rst_q;
	always_ff @(posedge core_clk)
	begin
		rtc_rst_q <= cur.rtc_rst;
	end

	assign hrdata                = cur.hrdata;
	assign hreadyout             = 1'b1;
	assign hresp                 = 1'b0;
	assign pll_prediv  = cur.regs[`IDX_PLL][`PLL_PREDIV_HI:`PLL_PREDIV_LO];
	assign pll_postdiv = cur.regs[`IDX_PLL][`PLL_POSTDIV_HI:`PLL_POSTDIV_LO];
	assign pll_mul     = cur.regs[`IDX_PLL][`PLL_MUL_HI:`PLL_MUL_LO];
	assign pll_ref_sel = cur.regs[`IDX_PLL][`PLL_REF_BIT];
	assign usb_clk_sel = src_word[`USB_SEL_HI:`USB_SEL_LO];
	assign system_clock_sel      = src_word[`SYS_SEL_HI:`SYS_SEL_LO];
	assign hclk_tick             = cur.hclk_tick;
	assign first_bus_tick        = cur.first_bus_tick;
	assign second_bus_tick       = cur.second_bus_tick;
	assign mco_pin               = cur.mco_pin;
	assign first_bus_module_rst  = cur.first_bus_module_rst;
	assign second_bus_module_rst = cur.second_bus_module_rst;
	assign ahb_module_rst        = cur.ahb_module_rst;
	assign rtc_rst               = rtc_rst_q;
	assign first_bus_run_gate    = cur.first_bus_run_gate;
	assign second_bus_clock_gate = cur.regs[`IDX_GATE1];
	assign ahb_clock_gate        = cur.regs[`IDX_GATEH];
endmodule // reset_clock_control_unit

// ---- verilog/rcc_params.svh ----
`ifndef RCC_PARAMS_SVH
`define RCC_PARAMS_SVH

// register byte offsets
`define OFF_PLL_CLOCK_SETTINGS      12'h000
`define OFF_CLOCK_SOURCE_CONTROL    12'h004
`define OFF_CLOCK_DIVIDER_CONFIG    12'h008
`define OFF_FIRST_BUS_MODULE_RESET  12'h010
`define OFF_SECOND_BUS_MODULE_RESET 12'h014
`define OFF_AHB_MODULE_RESET        12'h018
`define OFF_FIRST_BUS_CLOCK_GATE    12'h020
`define OFF_SECOND_BUS_CLOCK_GATE   12'h024
`define OFF_AHB_CLOCK_GATE          12'h028
`define OFF_FIRST_BUS_LOWPOWER_GATE 12'h030

// register file indices
`define IDX_PLL      4'h0
`define IDX_SRC      4'h1
`define IDX_DIV      4'h2
`define IDX_RST0     4'h3
`define IDX_RST1     4'h4
`define IDX_RSTH     4'h5
`define IDX_GATE0    4'h6
`define IDX_GATE1    4'h7
`define IDX_GATEH    4'h8
`define IDX_LPGATE0  4'h9
`define REG_COUNT    10

// writable bit masks
`define MASK_PLL     32'h1F03_7F01
`define MASK_SRC     32'h0000_0333
`define MASK_DIV     32'h7F00_3FF0
`define MASK_RST0    32'h1B11_4350
`define MASK_RST1    32'h0031_1050
`define MASK_RSTH    32'h0000_1404
`define MASK_GATE0   32'h1F11_5350
`define MASK_GATE1   32'h0231_1050
`define MASK_GATEH   32'h0000_9405
`define MASK_LPGATE0 32'h1F11_5350

// reset values
`define RST_PLL      32'h0300_0F00
`define RST_SRC      32'h0000_0033
`define RST_DIV      32'h0000_0000
`define RST_RST      32'h0000_0000
`define RST_GATE0    32'h0400_0000
`define RST_GATE1    32'h0000_0000
`define RST_GATEH    32'h0000_0001
`define RST_LPGATE0  32'h0400_0000

// field positions
`define PLL_PREDIV_HI   28
`define PLL_PREDIV_LO   24
`define PLL_POSTDIV_HI  17
`define PLL_POSTDIV_LO  16
`define PLL_MUL_HI      14
`define PLL_MUL_LO      8
`define PLL_REF_BIT     0
`define USB_SEL_HI      9
`define USB_SEL_LO      8
`define SYS_SEL_HI      5
`define SYS_SEL_LO      4
`define SECOND_BUS_BIT  1
`define FIRST_BUS_BIT   0
`define MCO_PRES_HI     30
`define MCO_PRES_LO     28
`define MCO_SEL_HI      27
`define MCO_SEL_LO      24
`define FIRST_PRES_HI   13
`define FIRST_PRES_LO   11
`define SECOND_PRES_HI  10
`define SECOND_PRES_LO  8
`define AHB_PRES_HI     7
`define AHB_PRES_LO     4
`define RTC_RESET_BIT   27

// prescaler limits
`define BUS_PRES_MAX    3'h4
`define MCO_PRES_MAX    3'h4
`define AHB_PRES_MAX    4'h9

`endif

// ---- verilog/rcc_pkg.sv ----
package rcc_pkg;

	typedef enum logic [1:0] {
		SYS_FAST_INTERNAL  = 2'b00,
		SYS_EXTERNAL       = 2'b01,
		SYS_PLL            = 2'b10,
		SYS_MULTISPEED     = 2'b11
	} sys_src_type;

	typedef enum logic [3:0] {
		MCO_OFF            = 4'b0000,
		MCO_SYSTEM         = 4'b0001,
		MCO_FAST_INTERNAL  = 4'b0010,
		MCO_MULTISPEED     = 4'b0011,
		MCO_EXTERNAL       = 4'b0100,
		MCO_PLL            = 4'b0101,
		MCO_SLOW_INTERNAL  = 4'b0110,
		MCO_SLOW_EXTERNAL  = 4'b0111,
		MCO_USB_INTERNAL   = 4'b1000
	} mco_src_type;

	typedef struct packed {
		logic [9:0][31:0] regs;
		logic             wr_pend;
		logic [3:0]       wr_idx;
		logic [31:0]      hrdata;
		logic             hclk_tick;
		logic             first_bus_tick;
		logic             second_bus_tick;
		logic [3:0]       mco_act;
		logic             mco_src_q;
		logic             mco_pin;
		logic [31:0]      first_bus_module_rst;
		logic [31:0]      second_bus_module_rst;
		logic [31:0]      ahb_module_rst;
		logic             rtc_rst;
		logic [31:0]      first_bus_run_gate;
	} state_type;

endpackage

// ---- verilog/clock_pow2_divider.sv ----
`timescale 1ns/100ps
// divides a tick stream by 2**div_sel; a new ratio takes effect only at
// the end of a whole output period, so no short period is ever produced
module clock_pow2_divider
	import rcc_pkg::*;
(
	input  wire logic       core_clk, // system clock
	input  wire logic       rst_b,    // sync reset, active low
	input  wire logic       tick_in,  // source tick
	input  wire logic [3:0] div_sel,  // log2 of division
	output logic            tick_out  // divided tick
);
	logic [8:0] cnt;
	logic [3:0] sel_act;
	logic [8:0] mask;
	logic       last;

	assign mask = 9'((10'h001 << sel_act) - 10'h001);
	assign last = (cnt & mask) == mask;
	assign tick_out = tick_in & last;

	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			cnt     <= 9'h000;
			sel_act <= 4'h0;
		end
		else if (tick_in)
		begin
			if (last)
			begin
				cnt     <= 9'h000;
				sel_act <= div_sel;
			end
			else
				cnt <= cnt + 9'h001;
		end
	end
endmodule // clock_pow2_divider

// ---- testbench/reset_clock_control_unit_assertions.sv ----
`timescale 1ns/100ps
module rcc_checker (
	input wire logic        core_clk,              // clock
	input wire logic        rst_b,                 // reset
	input wire logic [4:0]  pll_prediv,            // field
	input wire logic [6:0]  pll_mul,               // field
	input wire logic        pll_ref_sel,           // field
	input wire logic [1:0]  system_clock_sel,      // field
	input wire logic        low_power_wake,        // wake
	input wire logic [31:0] first_bus_module_rst,  // resets
	input wire logic        rtc_rst,               // rtc reset
	input wire logic [31:0] first_bus_run_gate,    // gates
	input wire logic [31:0] second_bus_clock_gate, // gates
	input wire logic [31:0] ahb_clock_gate,        // gates
	input wire logic        hclk_tick,             // tick
	input wire logic        mco_pin                // pin
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);

	a_prediv_rst: assert property ($rose(rst_b) |-> pll_prediv == 5'h03)
		else $error("prediv reset value wrong");
	a_mul_rst: assert property ($rose(rst_b) |->
		pll_mul == 7'h0F && !pll_ref_sel)
		else $error("multiplier or reference reset value wrong");
	a_sys_rst: assert property ($rose(rst_b) |-> system_clock_sel == 2'h3)
		else $error("system source not multispeed after reset");
	a_wake_sys: assert property (low_power_wake |->
		##[1:2] system_clock_sel == 2'h3)
		else $error("system source not multispeed after wake");
	a_gate_rst: assert property ($rose(rst_b) |->
		second_bus_clock_gate == 32'h0 && ahb_clock_gate == 32'h1)
		else $error("gate reset values wrong");
	a_rtc_apart: assert property ($past(rst_b) |->
		!first_bus_module_rst[27])
		else $error("rtc reset leaks into the module reset vector");
	a_gate0_bits: assert property (
		(first_bus_run_gate & ~32'h1F11_5350) == 32'h0)
		else $error("run gate on a reserved bit");
	a_rst0_bits: assert property ($past(rst_b) |->
		(first_bus_module_rst & ~32'h1B11_4350) == 32'h0)
		else $error("module reset on a reserved bit");
	a_ahb_bits: assert property (
		(ahb_clock_gate & ~32'h0000_9405) == 32'h0 &&
		(second_bus_clock_gate & ~32'h0231_1050) == 32'h0)
		else $error("clock gate on a reserved bit");

	c_wake: cover property (low_power_wake);
	c_mco: cover property ($rose(mco_pin));
	c_rtc: cover property ($rose(rtc_rst));
	c_tick: cover property ($fell(hclk_tick));
endmodule // rcc_checker

bind reset_clock_control_unit rcc_checker chk_u (
	.core_clk(core_clk), .rst_b(rst_b), .pll_prediv(pll_prediv),
	.pll_mul(pll_mul), .pll_ref_sel(pll_ref_sel),
	.system_clock_sel(system_clock_sel), .low_power_wake(low_power_wake),
	.first_bus_module_rst(first_bus_module_rst), .rtc_rst(rtc_rst),
	.first_bus_run_gate(first_bus_run_gate),
	.second_bus_clock_gate(second_bus_clock_gate),
	.ahb_clock_gate(ahb_clock_gate), .hclk_tick(hclk_tick),
	.mco_pin(mco_pin)
);

// ---- testbench/reset_clock_control_unit_tb.sv ----
`timescale 1ns/100ps
module reset_clock_control_unit_tb;
	logic        core_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        hsel = 1'b0;
	logic [11:0] haddr = 12'h000;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic        low_power_mode = 1'b0;
	logic        low_power_wake = 1'b0;
	logic [8:2]  osc = 7'h00;
	logic [31:0] hrdata, first_bus_module_rst, second_bus_module_rst;
	logic [31:0] ahb_module_rst, first_bus_run_gate, second_bus_clock_gate;
	logic [31:0] ahb_clock_gate;
	logic [4:0]  pll_prediv;
	logic [6:0]  pll_mul;
	logic [1:0]  pll_postdiv, usb_clk_sel, system_clock_sel;
	logic        pll_ref_sel, hclk_tick, first_bus_tick, second_bus_tick;
	logic        mco_pin, rtc_rst;
	int          bad_count = 0;
	int          comparisons = 0;
	int          cyc = 0;
	logic [11:0] offs [11] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010,
		12'h014, 12'h018, 12'h020, 12'h024, 12'h028, 12'h030};
	logic [31:0] rstv [11] = '{32'h0300_0F00, 32'h0000_0033, 32'h0, 32'h0,
		32'h0, 32'h0, 32'h0, 32'h0400_0000, 32'h0, 32'h1, 32'h0400_0000};
	logic [31:0] wmask [11] = '{32'h1F03_7F01, 32'h0000_0333,
		32'h7F00_3FF0, 32'h0, 32'h1B11_4350, 32'h0031_1050, 32'h0000_1404,
		32'h1F11_5350, 32'h0231_1050, 32'h0000_9405, 32'h1F11_5350};

	reset_clock_control_unit dut_u (
		.core_clk(core_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(1'b1),
		.hwdata(hwdata), .hrdata(hrdata), .hreadyout(), .hresp(),
		.fast_internal_osc(osc[2]), .multispeed_internal_osc(osc[3]),
		.external_osc(osc[4]), .pll_clk(osc[5]),
		.slow_internal_osc(osc[6]), .slow_external_osc(osc[7]),
		.usb_internal_osc(osc[8]), .low_power_mode(low_power_mode),
		.low_power_wake(low_power_wake), .pll_prediv(pll_prediv),
		.pll_postdiv(pll_postdiv), .pll_mul(pll_mul),
		.pll_ref_sel(pll_ref_sel), .usb_clk_sel(usb_clk_sel),
		.system_clock_sel(system_clock_sel), .hclk_tick(hclk_tick),
		.first_bus_tick(first_bus_tick), .second_bus_tick(second_bus_tick),
		.mco_pin(mco_pin), .first_bus_module_rst(first_bus_module_rst),
		.second_bus_module_rst(second_bus_module_rst),
		.ahb_module_rst(ahb_module_rst), .rtc_rst(rtc_rst),
		.first_bus_run_gate(first_bus_run_gate),
		.second_bus_clock_gate(second_bus_clock_gate),
		.ahb_clock_gate(ahb_clock_gate)
	);

	initial
	begin
		forever #2.5 core_clk = ~core_clk;
	end

	// oscillator k has a period of 2k cycles; also the hang limit
	always @(posedge core_clk)
	begin
		#1;
		cyc = cyc + 1;
		for (int k = 2; k <= 8; k++)
			osc[k] = ((cyc / k) % 2) == 1;
		if (cyc > 60000)
		begin
			bad_count++;
			complete_run();
		end
	end

	task automatic complete_run();
		if (bad_count == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wait_cycles(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic bus_op(input logic wr, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q);
		hsel = 1'b1;
		htrans = 2'h2;
		hwrite = wr;
		haddr = a;
		wait_cycles(1);
		hsel = 1'b0;
		htrans = 2'h0;
		hwdata = d;
		wait_cycles(1);
		q = hrdata;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus_op(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus_op(1'b0, a, 32'h0, q);
		check($sformatf("read %h", a), e, q);
	endtask

	function automatic logic sig(input int s);
		case (s)
			0: return hclk_tick;
			1: return first_bus_tick;
			2: return second_bus_tick;
			default: return mco_pin;
		endcase
	endfunction

	// interval between 2nd and 3rd event; the first one may be stale
	task automatic period(input int s, input int exp, input string what);
		int t0;
		int k;
		logic prev;
		logic v;
		k = 0;
		t0 = 0;
		prev = 1'b1;
		// let a tick launched before the write drain out
		wait_cycles(2);
		for (int i = 0; i < 4000 && k < 3; i++)
		begin
			v = sig(s);
			if (v && (s < 3 || !prev))
			begin
				k++;
				if (k == 3)
					check(what, 32'(exp), 32'(i - t0));
				t0 = i;
			end
			prev = v;
			wait_cycles(1);
		end
		if (k < 3)
			check(what, 32'(exp), 32'(k * 10000));
	endtask

	task automatic t_reset_values();
		for (int i = 0; i < 11; i++)
			rd(offs[i], rstv[i]);
		check("module resets", 32'h0, first_bus_module_rst);
		check("postdiv", 32'h0, 32'(pll_postdiv));
	endtask

	task automatic t_write_masks();
		for (int i = 0; i < 11; i++)
			wr(offs[i], 32'hFFFF_FFFF);
		for (int i = 0; i < 11; i++)
			rd(offs[i], wmask[i]);
		check("prediv", 32'h1F, 32'(pll_prediv));
		check("rtc reset", 32'h1, 32'(rtc_rst));
		check("bus2 resets", 32'h0031_1050, second_bus_module_rst);
		check("ahb resets", 32'h0000_1404, ahb_module_rst);
		check("ahb gates", 32'h0000_9405, ahb_clock_gate);
		for (int i = 0; i < 11; i++)
			wr(offs[i], rstv[i]);
		wait_cycles(3);
		check("resets released", 32'h0, first_bus_module_rst);
		check("rtc released", 32'h0, 32'(rtc_rst));
	endtask

	task automatic t_pll_fields();
		wr(12'h000, 32'h0A02_3501);
		wait_cycles(2);
		check("prediv", 32'h0A, 32'(pll_prediv));
		check("postdiv", 32'h2, 32'(pll_postdiv));
		check("mul", 32'h35, 32'(pll_mul));
		check("ref", 32'h1, 32'(pll_ref_sel));
		for (int u = 0; u < 3; u++)
		begin
			wr(12'h004, 32'(32'h33 | (u << 8)));
			wait_cycles(2);
			check("usb select", 32'(u), 32'(usb_clk_sel));
		end
		wr(12'h004, 32'h0000_0003);
		wait_cycles(2);
		check("sys select", 32'h0, 32'(system_clock_sel));
		low_power_wake = 1'b1;
		wait_cycles(1);
		low_power_wake = 1'b0;
		wait_cycles(2);
		check("wake select", 32'h3, 32'(system_clock_sel));
		wr(12'h004, 32'h0000_0033);
	endtask

	task automatic t_dividers();
		for (int v = 0; v < 10; v++)
		begin
			wr(12'h008, 32'(v << 4));
			period(0, 1 << v, "ahb period");
		end
		wr(12'h008, 32'h0000_00F0);
		period(0, 512, "ahb saturated");
		for (int p = 0; p < 5; p++)
		begin
			wr(12'h008, 32'((p << 11) | (p << 8) | 32'h10));
			period(1, 2 << p, "bus1 period");
			period(2, 2 << p, "bus2 period");
		end
		wr(12'h004, 32'h0000_0032);
		period(1, 0, "bus1 gated");
		period(2, 32, "bus2 running");
		wr(12'h004, 32'h0000_0033);
	endtask

	task automatic t_clock_out();
		wr(12'h008, 32'h0000_0000);
		period(3, 0, "mco off");
		for (int s = 2; s < 9; s++)
		begin
			wr(12'h008, 32'(s << 24));
			period(3, 2 * s, "mco source");
		end
		for (int p = 0; p < 5; p++)
		begin
			wr(12'h008, 32'((p << 28) | (1 << 24)));
			period(3, 2 << p, "mco divide");
		end
		wr(12'h008, 32'h0000_0000);
	endtask

	task automatic t_low_power();
		wr(12'h020, 32'h1F11_5350);
		wr(12'h030, 32'h0800_0000);
		low_power_mode = 1'b1;
		wait_cycles(3);
		check("lp gates", 32'h0800_0000, first_bus_run_gate);
		low_power_mode = 1'b0;
		wait_cycles(3);
		check("run gates", 32'h1F11_5350, first_bus_run_gate);
	endtask

	task automatic t_rtc_global();
		wr(12'h010, 32'h0800_0000);
		wait_cycles(3);
		check("rtc set", 32'h1, 32'(rtc_rst));
		wr(12'h010, 32'h0);
		wait_cycles(3);
		rst_b = 1'b0;
		wait_cycles(4);
		check("global resets", 32'hFFFF_FFFF, first_bus_module_rst);
		check("rtc kept", 32'h0, 32'(rtc_rst));
		rst_b = 1'b1;
		wait_cycles(1);
		t_reset_values();
	endtask

	initial
	begin
		wait_cycles(4);
		rst_b = 1'b1;
		wait_cycles(1);
		t_reset_values();
		t_write_masks();
		t_pll_fields();
		t_dividers();
		t_clock_out();
		t_low_power();
		t_rtc_global();
		complete_run();
	end
endmodule // reset_clock_control_unit_tb
